// >>> ssl_params.svh
/*
 status led sequencer constants: timebase, blink periods, code lengths.
 assumes a 20 MHz system clock.
*/
`ifndef SSL_PARAMS_SVH
`define SSL_PARAMS_SVH
`define SSL_CLK_HZ 20000000
`define SSL_TICK_MS 250
`define SSL_TICK_CYCLES ((`SSL_CLK_HZ / 1000) * `SSL_TICK_MS)
`define SSL_TICKS_PER_SEC 4
`define SSL_PAUSE_SEC 2
`define SSL_THERM_BLINKS 2
`define SSL_MEM_BLINKS 5
`define SSL_VID_BLINKS 6
`define SSL_ASM_BLINKS 7
`define SSL_ROM_BLINKS 8
`define SSL_FLASH_FAIL_BLINKS 2
`endif

// >>> ssl_pkg.sv
/*
 types for the status led sequencer.
 assumes ssl_params.svh supplies the numeric constants.
*/
package ssl_pkg;
   typedef enum logic [2:0] {
      SSL_PWR_OFF = 3'h0,
      SSL_PWR_S0 = 3'h1,
      SSL_PWR_S1 = 3'h2,
      SSL_PWR_S3 = 3'h3,
      SSL_PWR_S4 = 3'h4,
      SSL_PWR_S5 = 3'h5
   } ssl_pwr_e;
   typedef enum logic [3:0] {
      SSL_PH_IDLE = 4'h1,
      SSL_PH_BLINK = 4'h2,
      SSL_PH_PAUSE = 4'h4,
      SSL_PH_DONE = 4'h8
   } ssl_phase_e;
   typedef logic [22:0] ssl_div_t;
   typedef struct packed {
      ssl_div_t div;
      logic tick;
      logic [3:0] sub;
      logic [3:0] sec;
      ssl_phase_e phase;
      logic [3:0] code;
      logic flash_done;
      logic [1:0] kb_step;
      logic [2:0] kb_count;
      logic led_green;
      logic led_red;
      logic hdd_led;
      logic num_led;
      logic caps_led;
      logic scroll_led;
   } ssl_state_s;
endpackage : ssl_pkg

// >>> ssl_led_sequencer.sv
/*
 status led sequencer: power led, drive led and keyboard lock led codes.
 assumes status inputs are synchronous levels from firmware, 20 MHz clock.
*/
// Overview of operation
// [RL1] S0 without fault: power led steady green.
// [RL2] S1 and S3: power led blinks green at half a hertz.
// [RL3] S4, S5 or off: power led dark.
// [RL4] processor missing: power led steady red.
// [RL5] no memory installed: power led blinks red at two hertz.
// [RL6] thermal shutdown: red once per second two seconds, dark two seconds.
// [RL7] memory error: five red blinks one per second, two-second pause.
// [RL8] video error: six red blinks in six seconds, two-second pause.
// [RL9] board assembly failure: seven red blinks, two-second pause.
// [RL10] bad rom checksum: eight red blinks, two-second pause.
// [RL11] rom programming steady red; afterwards green blink once per second.
// [RL12] drive led green only during drive activity.
// [RL13] boot memory failure: num lock blinks, others off.
// [RL14] graphics failure: caps lock blinks, others off.
// [RL15] failure before graphics init: scroll lock blinks, others off.
// [RL16] recovery diskette or drive problem: num lock steady.
// [RL17] password prompt: caps lock steady, others off.
// [RL18] flash failed: all three lock leds blink together twice.
// [RL19] network lock: lock leds blink in order num, caps, scroll.
// [RL20] boot block update done: all three lock leds steady.
// [RL21] keyboard codes only to a ps/2 keyboard, never usb.
`timescale 1ns/1ps
`include "ssl_params.svh"
module ssl_led_sequencer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // power state and faults
   input wire ssl_pkg::ssl_pwr_e pwr_state,
   input wire logic cpu_missing,
   input wire logic no_memory,
   input wire logic thermal_trip,
   input wire logic mem_error,
   input wire logic video_error,
   input wire logic board_assembly_fail,
   input wire logic rom_checksum_bad,
   input wire logic rom_programming,
   input wire logic rom_program_done,
   input wire logic hdd_active,
   // boot diagnostics
   input wire logic kb_is_ps2,
   input wire logic boot_mem_fail,
   input wire logic boot_gfx_fail,
   input wire logic boot_pre_gfx_fail,
   input wire logic recovery_media_fail,
   input wire logic password_prompt,
   input wire logic flash_failed,
   input wire logic network_lock,
   input wire logic bootblock_ok,
   // leds
   output logic power_led_green,
   output logic power_led_red,
   output logic hdd_led,
   output logic num_led,
   output logic caps_led,
   output logic scroll_led
);
   import ssl_pkg::*;

   localparam ssl_div_t TICK_LAST = ssl_div_t'(`SSL_TICK_CYCLES - 1);
   localparam logic [3:0] TPS = 4'(`SSL_TICKS_PER_SEC);

   ssl_state_s r;
   ssl_state_s next_r;

   // blink-code length for the active red sequence, zero when none
   function automatic logic [3:0] code_len(input logic th, input logic me,
         input logic vi, input logic ba, input logic ro);
      if (th) begin
         code_len = 4'(`SSL_THERM_BLINKS);
      end else if (me) begin
         code_len = 4'(`SSL_MEM_BLINKS);
      end else if (vi) begin
         code_len = 4'(`SSL_VID_BLINKS);
      end else if (ba) begin
         code_len = 4'(`SSL_ASM_BLINKS);
      end else if (ro) begin
         code_len = 4'(`SSL_ROM_BLINKS);
      end else begin
         code_len = 4'h0;
      end
   endfunction : code_len

   logic [3:0] want;
   logic sec_end;
   logic half_on;
   logic fast_on;
   logic slow_on;
   logic kb_on;

   always_comb begin
      next_r = r;
      want = code_len(thermal_trip, mem_error, video_error,
            board_assembly_fail, rom_checksum_bad);
      next_r.tick = (r.div == TICK_LAST);
      next_r.div = next_r.tick ? '0 : ssl_div_t'(r.div + 1'b1);
      sec_end = r.tick && (r.sub == TPS - 4'h1);
      if (r.tick) begin
         next_r.sub = sec_end ? 4'h0 : 4'(r.sub + 4'h1);
      end
      // 4 ticks a second: on for the first half
      half_on = (r.sub < 4'h2);
      fast_on = r.sub[0];
      // 0.5 Hz: one second on, one second off
      slow_on = ~r.sec[0];

      // coded red sequences restart when the code changes
      if (want != r.code) begin
         next_r.code = want;
         next_r.phase = (want == 4'h0) ? SSL_PH_IDLE : SSL_PH_BLINK;
         next_r.sec = 4'h0;
         next_r.sub = 4'h0;
         next_r.div = '0;
      end else if (sec_end) begin
         case (r.phase)
            SSL_PH_BLINK: begin
               if (r.sec == 4'(r.code - 4'h1)) begin
                  next_r.phase = SSL_PH_PAUSE; // [RL6] [RL7] [RL8] [RL9] [RL10]
                  next_r.sec = 4'h0;
               end else begin
                  next_r.sec = 4'(r.sec + 4'h1);
               end
            end
            SSL_PH_PAUSE: begin
               if (r.sec == 4'(`SSL_PAUSE_SEC - 1)) begin
                  next_r.phase = SSL_PH_BLINK;
                  next_r.sec = 4'h0;
               end else begin
                  next_r.sec = 4'(r.sec + 4'h1);
               end
            end
            default: begin
               next_r.sec = 4'(r.sec + 4'h1);
            end
         endcase
      end

      // rom programming completion latch
      if (rom_programming) begin
         next_r.flash_done = 1'b0;
      end else if (rom_program_done) begin
         next_r.flash_done = 1'b1;
      end

      // power led priority: faults first, then power state
      next_r.led_green = 1'b0;
      next_r.led_red = 1'b0;
      if (rom_programming) begin
         next_r.led_red = 1'b1; // [RL11]
      end else if (r.flash_done) begin
         next_r.led_green = half_on; // [RL11]
      end else if (cpu_missing) begin
         next_r.led_red = 1'b1; // [RL4]
      end else if (r.code != 4'h0 && r.code == want) begin
         next_r.led_red = (r.phase == SSL_PH_BLINK) && half_on; // [RL6] [RL7] [RL8] [RL9] [RL10]
      end else if (no_memory) begin
         next_r.led_red = fast_on; // [RL5]
      end else begin
         case (pwr_state)
            SSL_PWR_S0: next_r.led_green = 1'b1; // [RL1]
            SSL_PWR_S1, SSL_PWR_S3: next_r.led_green = slow_on; // [RL2]
            default: next_r.led_green = 1'b0; // [RL3]
         endcase
      end

      next_r.hdd_led = hdd_active; // [RL12]

      // network lock walk: one led per second
      if (!network_lock) begin
         next_r.kb_step = 2'h0;
      end else if (sec_end) begin
         next_r.kb_step = (r.kb_step == 2'h2) ? 2'h0 : 2'(r.kb_step + 2'h1);
      end
      // flash failure: count four one-second phases (two lit), then stay dark
      if (!flash_failed) begin
         next_r.kb_count = 3'h0;
      end else if (sec_end && r.kb_count < 3'(2 * `SSL_FLASH_FAIL_BLINKS)) begin
         next_r.kb_count = 3'(r.kb_count + 3'h1);
      end
      kb_on = half_on && !r.kb_count[0]
            && (r.kb_count < 3'(2 * `SSL_FLASH_FAIL_BLINKS));

      next_r.num_led = 1'b0;
      next_r.caps_led = 1'b0;
      next_r.scroll_led = 1'b0;
      // usb keyboards get nothing, so lock leds stay dark
      if (kb_is_ps2) begin // [RL21]
         if (flash_failed) begin
            next_r.num_led = kb_on; // [RL18]
            next_r.caps_led = kb_on;
            next_r.scroll_led = kb_on;
         end else if (bootblock_ok) begin
            next_r.num_led = 1'b1; // [RL20]
            next_r.caps_led = 1'b1;
            next_r.scroll_led = 1'b1;
         end else if (network_lock) begin
            next_r.num_led = (r.kb_step == 2'h0); // [RL19]
            next_r.caps_led = (r.kb_step == 2'h1);
            next_r.scroll_led = (r.kb_step == 2'h2);
         end else if (boot_mem_fail) begin
            next_r.num_led = half_on; // [RL13]
         end else if (boot_gfx_fail) begin
            next_r.caps_led = half_on; // [RL14]
         end else if (boot_pre_gfx_fail) begin
            next_r.scroll_led = half_on; // [RL15]
         end else if (recovery_media_fail) begin
            next_r.num_led = 1'b1; // [RL16]
         end else if (password_prompt) begin
            next_r.caps_led = 1'b1; // [RL17]
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '{div: '0, tick: 1'b0, sub: 4'h0, sec: 4'h0, phase: SSL_PH_IDLE,
               code: 4'h0, flash_done: 1'b0, kb_step: 2'h0, kb_count: 3'h0,
               led_green: 1'b0, led_red: 1'b0, hdd_led: 1'b0, num_led: 1'b0,
               caps_led: 1'b0, scroll_led: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign power_led_green = r.led_green;
   assign power_led_red = r.led_red;
   assign hdd_led = r.hdd_led;
   assign num_led = r.num_led;
   assign caps_led = r.caps_led;
   assign scroll_led = r.scroll_led;
endmodule : ssl_led_sequencer

// >>> ssl_fw_model.sv
/*
 firmware side model: raises the requested status lines.
 assumes the bench changes requests at the rising clock edge.
*/
`timescale 1ns/1ps
module ssl_fw_model (
   // request
   input wire logic [17:0] ev,
   // status lines
   output logic [17:0] st
);
   // levels pass straight through, so a status line is unknown whenever its request bit is
   always_comb begin
      st = ev;
   end
endmodule : ssl_fw_model

// >>> ssl_led_sequencer_asserts.sv
/*
 port checker for the status led sequencer, steady codes.
 assumes bind onto ssl_led_sequencer; a done pulse is followed by reprogramming.
*/
`timescale 1ns/1ps
module ssl_led_sequencer_asserts (
   // clock and reset
   input logic clk,
   input logic rst,
   // status inputs
   input ssl_pkg::ssl_pwr_e pwr_state,
   input logic cpu_missing,
   input logic no_memory,
   input logic thermal_trip,
   input logic mem_error,
   input logic video_error,
   input logic board_assembly_fail,
   input logic rom_checksum_bad,
   input logic rom_programming,
   input logic rom_program_done,
   input logic hdd_active,
   input logic kb_is_ps2,
   input logic boot_mem_fail,
   input logic boot_gfx_fail,
   input logic boot_pre_gfx_fail,
   input logic recovery_media_fail,
   input logic password_prompt,
   input logic flash_failed,
   input logic network_lock,
   input logic bootblock_ok,
   // leds
   input logic power_led_green,
   input logic power_led_red,
   input logic hdd_led,
   input logic num_led,
   input logic caps_led,
   input logic scroll_led
);
   import ssl_pkg::*;
   logic live;
   wire pwr_flt = cpu_missing | no_memory | thermal_trip | mem_error | video_error
      | board_assembly_fail | rom_checksum_bad | rom_programming | rom_program_done;
   wire lock_hi = flash_failed | bootblock_ok | network_lock;
   wire kb_ok = kb_is_ps2 & !lock_hi & !boot_mem_fail & !boot_gfx_fail & !boot_pre_gfx_fail;
   wire off_st = pwr_state inside {SSL_PWR_OFF, SSL_PWR_S4, SSL_PWR_S5};
   wire [2:0] kb = {num_led, caps_led, scroll_led};
   // first edge after reset still sees inputs from during reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         live <= 1'b0;
      end else begin
         live <= 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_hdd_follows: assert property (live |-> hdd_led == $past(hdd_active))
      else $error("drive led wrong");
   a_usb_dark: assert property (live && !$past(kb_is_ps2) |-> kb == 3'h0)
      else $error("lock led lit for usb");
   a_prog_red: assert property (live && $past(rom_programming) |-> power_led_red && !power_led_green)
      else $error("no steady red while programming");
   a_cpu_red: assert property (live && $past(cpu_missing) |-> power_led_red && !power_led_green)
      else $error("no steady red for missing cpu");
   a_s0_green: assert property (
      live && $past(pwr_state == SSL_PWR_S0 && !pwr_flt) |-> power_led_green && !power_led_red)
      else $error("no steady green in s0");
   a_off_dark: assert property (
      live && $past(off_st && !pwr_flt) |-> !power_led_green && !power_led_red)
      else $error("power led lit while off");
   a_boot_ok_all: assert property (
      live && $past(kb_is_ps2 && bootblock_ok && !flash_failed) |-> kb == 3'h7)
      else $error("lock leds not all on");
   a_media_num: assert property (live && $past(kb_ok && recovery_media_fail) |-> kb == 3'h4)
      else $error("num lock not alone");
   a_pass_caps: assert property (
      live && $past(kb_ok && !recovery_media_fail && password_prompt) |-> kb == 3'h2)
      else $error("caps lock not alone");
   a_mem_quiet: assert property (
      live && $past(kb_is_ps2 && !lock_hi && boot_mem_fail) |-> !caps_led && !scroll_led)
      else $error("caps or scroll lit on memory failure");
   c_green: cover property (power_led_green && !power_led_red);
   c_red: cover property (power_led_red && hdd_led);
   c_all_locks: cover property (kb == 3'h7);
endmodule : ssl_led_sequencer_asserts
bind ssl_led_sequencer ssl_led_sequencer_asserts u_chk (.*);

// >>> test_system_status_led_sequencer.sv
/*
 testbench for the status led sequencer: steady codes, priority, reset.
 assumes ssl_fw_model; blink timing lies beyond this run length.
*/
`timescale 1ns/1ps
module test_system_status_led_sequencer;
   import ssl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [17:0] ev = 18'h0;
   logic [17:0] st;
   ssl_pwr_e pwr = SSL_PWR_OFF;
   logic ps2 = 1'b1;
   logic [5:0] led;
   int n_mismatch = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   ssl_fw_model fw (.ev(ev), .st(st));
   ssl_led_sequencer uut (.clk(clk), .rst(rst), .pwr_state(pwr), .kb_is_ps2(ps2),
      .cpu_missing(st[0]), .no_memory(st[1]), .thermal_trip(st[2]), .mem_error(st[3]),
      .video_error(st[4]), .board_assembly_fail(st[5]), .rom_checksum_bad(st[6]),
      .rom_programming(st[7]), .rom_program_done(st[8]), .hdd_active(st[9]),
      .boot_mem_fail(st[10]), .boot_gfx_fail(st[11]), .boot_pre_gfx_fail(st[12]),
      .recovery_media_fail(st[13]), .password_prompt(st[14]), .flash_failed(st[15]),
      .network_lock(st[16]), .bootblock_ok(st[17]), .power_led_green(led[5]),
      .power_led_red(led[4]), .hdd_led(led[3]), .num_led(led[2]), .caps_led(led[1]),
      .scroll_led(led[0]));
   task automatic chk(input string what, input logic [5:0] exp);
      num_checks++;
      if (led !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, led);
      end
   endtask : chk
   task automatic put(input logic [17:0] e, input ssl_pwr_e p, input logic k);
      @(posedge clk);
      ev <= e;
      pwr <= p;
      ps2 <= k;
      repeat (3) @(posedge clk);
      #1;
   endtask : put
   task automatic t_power;
      put(18'h0, SSL_PWR_S0, 1'b1);
      chk("s0", 6'h20);
      put(18'h0, SSL_PWR_S1, 1'b1);
      chk("s1 on phase", 6'h20);
      put(18'h0, SSL_PWR_S3, 1'b1);
      chk("s3 on phase", 6'h20);
      put(18'h0, SSL_PWR_S4, 1'b1);
      chk("s4", 6'h00);
      put(18'h0, SSL_PWR_S5, 1'b1);
      chk("s5", 6'h00);
      put(18'h0, SSL_PWR_OFF, 1'b1);
      chk("off", 6'h00);
      $display("power states done");
   endtask : t_power
   task automatic t_red;
      // cpu fault must win over a running thermal code and stay steady
      put(18'h00005, SSL_PWR_S0, 1'b1);
      chk("cpu", 6'h10);
      repeat (40) @(posedge clk);
      chk("cpu later", 6'h10);
      put(18'h00080, SSL_PWR_S0, 1'b1);
      chk("programming", 6'h10);
      put(18'h00100, SSL_PWR_S0, 1'b1);
      chk("restart allowed", 6'h20);
      put(18'h00080, SSL_PWR_S0, 1'b1);
      chk("reprogramming", 6'h10);
      // each new code restarts at the start of a lit half second
      put(18'h00004, SSL_PWR_S0, 1'b1);
      chk("thermal", 6'h10);
      put(18'h00008, SSL_PWR_S0, 1'b1);
      chk("memory code", 6'h10);
      put(18'h00010, SSL_PWR_S0, 1'b1);
      chk("video code", 6'h10);
      put(18'h00020, SSL_PWR_S0, 1'b1);
      chk("assembly code", 6'h10);
      put(18'h00040, SSL_PWR_S0, 1'b1);
      chk("checksum code", 6'h10);
      $display("red codes done");
   endtask : t_red
   task automatic t_hdd;
      put(18'h00200, SSL_PWR_S4, 1'b1);
      chk("hdd", 6'h08);
      put(18'h00200, SSL_PWR_S0, 1'b1);
      chk("hdd s0", 6'h28);
      put(18'h0, SSL_PWR_S0, 1'b1);
      chk("hdd idle", 6'h20);
      $display("drive led done");
   endtask : t_hdd
   task automatic t_kb;
      put(18'h02000, SSL_PWR_OFF, 1'b1);
      chk("media", 6'h04);
      put(18'h04000, SSL_PWR_OFF, 1'b1);
      chk("password", 6'h02);
      put(18'h24000, SSL_PWR_OFF, 1'b1);
      chk("boot block", 6'h07);
      put(18'h24000, SSL_PWR_OFF, 1'b0);
      chk("usb", 6'h00);
      // timebase has not ticked yet, so blinks sit in their lit half
      put(18'h00400, SSL_PWR_OFF, 1'b1);
      chk("boot memory", 6'h04);
      put(18'h00800, SSL_PWR_OFF, 1'b1);
      chk("graphics", 6'h02);
      put(18'h01000, SSL_PWR_OFF, 1'b1);
      chk("pre graphics", 6'h01);
      put(18'h10000, SSL_PWR_OFF, 1'b1);
      chk("network first", 6'h04);
      put(18'h08000, SSL_PWR_OFF, 1'b1);
      chk("flash failed", 6'h07);
      $display("keyboard codes done");
   endtask : t_kb
   task automatic t_reset;
      put(18'h20000, SSL_PWR_S0, 1'b1);
      rst <= 1'b1;
      @(posedge clk);
      #1;
      chk("mid reset", 6'h00);
      rst <= 1'b0;
      put(18'h20000, SSL_PWR_S0, 1'b1);
      chk("after reset", 6'h27);
      $display("reset done");
   endtask : t_reset
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (10) @(posedge clk);
      chk("reset", 6'h00);
      rst <= 1'b0;
      t_power;
      t_red;
      t_hdd;
      t_kb;
      t_reset;
      finish_test;
   end
   initial begin
      #200000;
      n_mismatch++;
      finish_test;
   end
endmodule : test_system_status_led_sequencer
